// ===== common/itc_defines.svh
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH
//----------------------------------------------------------------
// Register map
//----------------------------------------------------------------
`define ITC_ADDR_W          4
`define ITC_OFF_CTRL        4'h4
`define ITC_OFF_MODE        4'h8
`define ITC_OFF_STAT        4'hC
`define ITC_CTRL_RESET      32'h0000_0000
`define ITC_BIT_DIR         10
`define ITC_BIT_LEN         11
`define ITC_BIT_HDR         12
`define ITC_BIT_START       13
`define ITC_BIT_STOP        14
`define ITC_BIT_NACK        15
`define ITC_CNT_LSB         16
`define ITC_CNT_MSB         23
`define ITC_BIT_RELOAD      24
`define ITC_BIT_AUTOEND     25
`define ITC_BIT_ON          0
`define ITC_BIT_MASTER      1
`define ITC_BIT_BYTECTL     2
`define ITC_BIT_PEC         3
`endif

// ===== common/itc_pkg.sv
package itc_pkg;
    typedef enum logic [1:0] {ITC_ACK_BUS, ITC_ACK_NACK, ITC_ACK_REQ} itc_ack_src_t;
endpackage

// ===== rtl/itc_transfer_control.sv
`timescale 1ns/10ps
`include "itc_defines.svh"
module itc_transfer_control (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Events from the bus sequencer
    input  wire logic        start_sent,
    input  wire logic        arb_lost,
    input  wire logic        timeout_err,
    input  wire logic        stop_sent,
    input  wire logic        stop_nack_sent,
    input  wire logic        addr_match,
    input  wire logic        address_match_clear,
    input  wire logic        bus_idle,
    input  wire logic        byte_done,
    input  wire logic        receiving,
    input  wire logic        overrun,
    input  wire logic        pec_byte,
    input  wire logic        pec_ok,
    // Sequencer requests
    output logic      [9:0]  target_address,
    output logic             transfer_direction,
    output logic             target_address_length,
    output logic             ten_bit_header_only,
    output logic             issue_start,
    output logic             issue_restart,
    output logic             issue_stop,
    output logic             ack_nack,
    output itc_pkg::itc_ack_src_t ack_src,
    output logic             reload_wait_flag,
    output logic             hold_clock_low,
    output logic      [7:0]  bytes_left
);
    import itc_pkg::*;

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [3:0]  mode;
    logic [7:0]  remain;
    logic        waiting;
    logic        rd_done;

    wire peripheral_on      = mode[`ITC_BIT_ON];
    wire master_mode        = mode[`ITC_BIT_MASTER];
    wire target_byte_control = mode[`ITC_BIT_BYTECTL];
    wire pec_on             = mode[`ITC_BIT_PEC];
    wire count_reload_on    = ctrl[`ITC_BIT_RELOAD];
    wire auto_end_mode      = ctrl[`ITC_BIT_AUTOEND];
    wire start_req          = ctrl[`ITC_BIT_START];
    wire stop_req           = ctrl[`ITC_BIT_STOP];
    wire not_acknowledge_request = ctrl[`ITC_BIT_NACK];

    //----------------------------------------------------------------
    // Bus decode
    //----------------------------------------------------------------
    wire sel_ctrl = (avs_address == `ITC_OFF_CTRL);
    wire sel_mode = (avs_address == `ITC_OFF_MODE);
    wire sel_stat = (avs_address == `ITC_OFF_STAT);
    wire wr_ctrl  = avs_write && sel_ctrl;
    wire wr_mode  = avs_write && sel_mode && avs_byteenable[0];
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wdata = (avs_writedata & be_mask) | (ctrl & ~be_mask);

    // Count field writable only while no start pending
    wire cnt_lock = start_req;
    // Start ignored while reload mode set
    wire sw_start = wr_ctrl && wdata[`ITC_BIT_START] && !wdata[`ITC_BIT_RELOAD];
    wire sw_stop  = wr_ctrl && wdata[`ITC_BIT_STOP];
    wire sw_nack  = wr_ctrl && wdata[`ITC_BIT_NACK];

    // Hardware clear conditions
    wire hw_clr_start = start_sent || arb_lost || timeout_err || !peripheral_on
                        || address_match_clear;
    wire hw_clr_stop  = stop_sent || !peripheral_on;
    wire hw_clr_nack  = stop_nack_sent || addr_match || !peripheral_on;

    //----------------------------------------------------------------
    // Request bit update
    //----------------------------------------------------------------
    // Shared by start, stop and nack: set by software, clear by hardware
    function automatic logic next_request(
        input logic cur,
        input logic set,
        input logic clr
    );
        // Clear first, so a late set cannot revive a finished request
        next_request = clr ? 1'b0 : (cur || set);
    endfunction

    // Writing 0 leaves request bits unchanged; hardware clear wins
    wire next_start = next_request(start_req, sw_start, hw_clr_start);
    wire next_stop  = next_request(stop_req, sw_stop, hw_clr_stop);
    wire next_nack  = next_request(not_acknowledge_request, sw_nack, hw_clr_nack);

    wire [31:0] wr_val = {6'h00, wdata[25:24],
                          cnt_lock ? ctrl[23:16] : wdata[23:16],
                          3'h0, wdata[12:0]};
    wire [31:0] base   = wr_ctrl ? wr_val : ctrl;
    wire [31:0] next_ctrl = {base[31:16], next_nack, next_stop, next_start, base[12:0]};

    //----------------------------------------------------------------
    // Byte counting
    //----------------------------------------------------------------
    // Count ignored in slave mode without byte control
    wire count_used = master_mode || target_byte_control;
    wire last_byte  = count_used && (remain == 8'h01);
    wire count_end  = byte_done && last_byte;
    wire load_cnt   = start_sent || (waiting && wr_ctrl && !cnt_lock);
    wire [7:0] next_remain = load_cnt ? next_ctrl[`ITC_CNT_MSB:`ITC_CNT_LSB] :
                             (byte_done && remain != 8'h00) ? remain - 8'h01 : remain;
    wire next_waiting = !peripheral_on ? 1'b0 :
                        (count_end && count_reload_on) ? 1'b1 :
                        load_cnt ? 1'b0 : waiting;

    //----------------------------------------------------------------
    // State registers
    //----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= `ITC_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode <= 4'h0;
        end else if (wr_mode) begin
            mode <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            remain <= 8'h00;
        end else begin
            remain <= next_remain;
        end
    end

    // Reload wait: count end sets, reload write or disable clears
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waiting <= 1'b0;
        end else begin
            waiting <= next_waiting;
        end
    end

    // One wait cycle per read, so read data comes from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= avs_read && !rd_done;
        end
    end

    //----------------------------------------------------------------
    // Read path
    //----------------------------------------------------------------
    wire [31:0] stat_word = {14'h0000, waiting, remain, 9'h000};
    wire [31:0] rd_mux = sel_ctrl ? ctrl :
                         sel_mode ? {28'h000_0000, mode} :
                         sel_stat ? stat_word : 32'h0000_0000;

    // Read data stands until the next read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read) begin
            avs_readdata <= rd_mux;
        end
    end

    // Writes complete at once, reads after one wait cycle
    assign avs_waitrequest = avs_read && !rd_done;

    //----------------------------------------------------------------
    // Sequencer outputs
    //----------------------------------------------------------------
    // 7-bit mode masks bits 0 and 9:8
    assign target_address = ctrl[`ITC_BIT_LEN] ? ctrl[9:0]
                                               : {2'b00, ctrl[7:1], 1'b0};
    assign transfer_direction    = ctrl[`ITC_BIT_DIR];
    assign target_address_length = ctrl[`ITC_BIT_LEN];
    // Header-only form selects short 10-bit read sequence
    assign ten_bit_header_only   = ctrl[`ITC_BIT_HDR];
    assign issue_restart = start_req && master_mode;
    assign issue_start   = start_req && !master_mode && bus_idle;
    assign issue_stop    = (stop_req && master_mode)
                           || (count_end && master_mode && auto_end_mode
                               && !count_reload_on);
    assign reload_wait_flag = waiting;
    assign hold_clock_low   = waiting;
    assign bytes_left       = remain;

    // Acknowledge selection for received bytes
    wire auto_nack = (master_mode && receiving && last_byte)
                     || (!master_mode && overrun);
    assign ack_src = (pec_on && pec_byte) ? ITC_ACK_BUS :
                     auto_nack ? ITC_ACK_NACK : ITC_ACK_REQ;
    assign ack_nack = (ack_src == ITC_ACK_BUS)  ? !pec_ok :
                      (ack_src == ITC_ACK_NACK) ? 1'b1 : not_acknowledge_request;

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    hw_start_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        hw_clr_start
        |=> !start_req)
        else $error("start not cleared");

    reload_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!start_req && wr_ctrl && wdata[`ITC_BIT_RELOAD])
        |=> !start_req)
        else $error("start set under reload");

    stop_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        hw_clr_stop
        |=> !stop_req)
        else $error("stop not cleared");

    nack_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        hw_clr_nack
        |=> !not_acknowledge_request)
        else $error("nack not cleared");

    count_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
        (start_req && !start_sent)
        |=> $stable(ctrl[23:16]))
        else $error("count changed");

    addr_seven_a: assert property (@(posedge ref_clk) disable iff (rst)
        !target_address_length
        |-> (target_address[9:8] == 2'b00 && !target_address[0]))
        else $error("7-bit address leak");

    overrun_nack_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!master_mode && overrun && !(pec_on && pec_byte))
        |-> ack_nack)
        else $error("overrun not nacked");

    reload_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        (count_end && count_reload_on && peripheral_on)
        |=> hold_clock_low)
        else $error("reload wait missing");

    zero_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stop_req && !hw_clr_stop)
        |=> stop_req)
        else $error("stop dropped");

    reset_ctrl_a: assert property (@(posedge ref_clk)
        ($past(rst) && !rst)
        |-> (ctrl == `ITC_CTRL_RESET))
        else $error("control not reset");

    reset_count_a: assert property (@(posedge ref_clk)
        ($past(rst) && !rst)
        |-> (remain == 8'h00 && !waiting))
        else $error("counter not reset");

    addr_ten_a: assert property (@(posedge ref_clk) disable iff (rst)
        target_address_length
        |-> (target_address == ctrl[9:0]))
        else $error("10-bit address wrong");

    addr_mid_a: assert property (@(posedge ref_clk) disable iff (rst)
        !target_address_length
        |-> (target_address[7:1] == ctrl[7:1]))
        else $error("7-bit address wrong");

    dir_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && avs_byteenable[1])
        |=> (transfer_direction == $past(avs_writedata[`ITC_BIT_DIR])))
        else $error("direction not stored");

    len_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && avs_byteenable[1])
        |=> (target_address_length == $past(avs_writedata[`ITC_BIT_LEN])))
        else $error("length not stored");

    hdr_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && avs_byteenable[1])
        |=> (ten_bit_header_only == $past(avs_writedata[`ITC_BIT_HDR])))
        else $error("header option not stored");

    start_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (start_req && !hw_clr_start)
        |=> start_req)
        else $error("start dropped");

    start_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && wdata[`ITC_BIT_START] && !wdata[`ITC_BIT_RELOAD] && !hw_clr_start)
        |=> start_req)
        else $error("start not set");

    restart_issue_a: assert property (@(posedge ref_clk) disable iff (rst)
        (start_req && master_mode)
        |-> issue_restart)
        else $error("restart not issued");

    idle_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        (start_req && !master_mode)
        |-> (issue_start == bus_idle))
        else $error("start not tied to idle");

    no_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        !start_req
        |-> (!issue_start && !issue_restart))
        else $error("start without request");

    stop_issue_a: assert property (@(posedge ref_clk) disable iff (rst)
        (stop_req && master_mode)
        |-> issue_stop)
        else $error("stop not issued");

    stop_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && wdata[`ITC_BIT_STOP] && !hw_clr_stop)
        |=> stop_req)
        else $error("stop not set");

    nack_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (not_acknowledge_request && !hw_clr_nack)
        |=> not_acknowledge_request)
        else $error("nack dropped");

    nack_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!master_mode && !overrun && !(pec_on && pec_byte))
        |-> (ack_nack == not_acknowledge_request))
        else $error("nack answer wrong");

    master_nack_a: assert property (@(posedge ref_clk) disable iff (rst)
        (master_mode && receiving && last_byte && !(pec_on && pec_byte))
        |-> ack_nack)
        else $error("last byte not nacked");

    pec_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pec_on && pec_byte)
        |-> (ack_nack == !pec_ok))
        else $error("check byte answer wrong");

    count_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        start_sent
        |=> (remain == $past(next_ctrl[`ITC_CNT_MSB:`ITC_CNT_LSB])))
        else $error("count not loaded");

    count_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        (byte_done && !load_cnt && remain != 8'h00)
        |=> (remain == $past(remain) - 8'h01))
        else $error("count not stepped");

    slave_count_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!master_mode && !target_byte_control)
        |-> !last_byte)
        else $error("count used in slave");

    auto_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (count_end && master_mode && auto_end_mode && !count_reload_on)
        |-> issue_stop)
        else $error("auto stop missing");

    reload_no_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (count_end && count_reload_on && !stop_req)
        |-> !issue_stop)
        else $error("stop under reload");

    rd_data_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !avs_read
        |=> $stable(avs_readdata))
        else $error("read data moved");
endmodule

// ===== tb/itc_seq_model.sv
`timescale 1ns/10ps
module itc_seq_model (
    // Clock, reset and pacing
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic hold,
    // Requests from the control block
    input  wire logic issue_start,
    input  wire logic issue_restart,
    input  wire logic issue_stop,
    // Bus events back
    output logic      start_sent,
    output logic      stop_sent,
    output logic      bus_idle
);
    logic busy;
    assign bus_idle = !busy;
    //----------------------------------------------------------------
    // One event pulse per request, withheld while hold is high
    //----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_sent <= 1'b0;
            stop_sent  <= 1'b0;
            busy       <= 1'b0;
        end else begin
            start_sent <= (issue_start || issue_restart) && !hold && !start_sent;
            stop_sent  <= issue_stop && !hold && !stop_sent;
            busy       <= (busy || start_sent) && !stop_sent;
        end
    end
endmodule

// ===== tb/test_itc_transfer_control.sv
`timescale 1ns/10ps
module test_itc_transfer_control;
    logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [4:0]  ev = 5'h00;
    logic [7:0]  left;
    logic        rwf, hcl;
    itc_pkg::itc_ack_src_t src;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic        avs_waitrequest, start_sent, stop_sent, bus_idle, ack_nack;
    logic        hold = 1'b1, receiving = 1'b1, overrun = 1'b0;
    logic [9:0]  target_address;
    logic        transfer_direction, target_address_length, ten_bit_header_only;
    logic        issue_start, issue_restart, issue_stop;
    int          fail_count = 0, checks = 0;
    logic [31:0] cw [3] = '{32'h0000_05FF, 32'h0000_0BFF, 32'h0000_1C01};
    logic [12:0] ce [3] = '{13'h04FE, 13'h0BFF, 13'h1C01};
    initial forever #50 ref_clk = ~ref_clk;
    itc_transfer_control u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .start_sent(start_sent), .arb_lost(ev[0]), .timeout_err(ev[1]), .stop_sent(stop_sent),
        .stop_nack_sent(1'b0), .addr_match(ev[3]), .address_match_clear(ev[2]),
        .bus_idle(bus_idle), .byte_done(ev[4]), .receiving(receiving), .overrun(overrun),
        .pec_byte(1'b0), .pec_ok(1'b0), .target_address(target_address),
        .transfer_direction(transfer_direction), .target_address_length(target_address_length),
        .ten_bit_header_only(ten_bit_header_only), .issue_start(issue_start),
        .issue_restart(issue_restart), .issue_stop(issue_stop), .ack_nack(ack_nack),
        .ack_src(src), .reload_wait_flag(rwf), .hold_clock_low(hcl), .bytes_left(left));
    itc_seq_model u_seq (.ref_clk(ref_clk), .rst(rst), .hold(hold), .issue_start(issue_start),
        .issue_restart(issue_restart), .issue_stop(issue_stop), .start_sent(start_sent),
        .stop_sent(stop_sent), .bus_idle(bus_idle));
    //----------------------------------------------------------------
    // Bus cycles, compares and the verdict
    //----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev <= 5'h01 << i;
        @(posedge ref_clk);
        ev <= 5'h00;
        #1;
    endtask
    task automatic release_seq(input logic h);
        @(posedge ref_clk);
        hold <= h;
        for (int k = 0; k < 8 && (issue_restart || issue_stop); k++) @(posedge ref_clk);
    endtask
    initial begin
        repeat (2000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(4'h4, 32'h0000_0000);
        rd(4'h0, 32'h0000_0000);
        acc(1'b1, 4'h8, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 4'h4, cw[i]);
            chk({ten_bit_header_only, target_address_length, transfer_direction,
                target_address}, ce[i]);
            rd(4'h4, cw[i]);
        end
        acc(1'b1, 4'h4, 32'h0005_2000);
        chk(issue_restart, 1'b1);
        acc(1'b1, 4'h4, 32'h0009_0000);
        rd(4'h4, 32'h0005_2000);
        release_seq(1'b0);
        rd(4'h4, 32'h0005_0000);
        release_seq(1'b1);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 4'h4, 32'h0000_2000);
            pulse(i);
            rd(4'h4, 32'h0000_0000);
        end
        acc(1'b1, 4'h4, 32'h0100_2000);
        rd(4'h4, 32'h0100_0000);
        acc(1'b1, 4'h4, 32'h0000_4000);
        chk(issue_stop, 1'b1);
        release_seq(1'b0);
        rd(4'h4, 32'h0000_0000);
        release_seq(1'b1);
        acc(1'b1, 4'h4, 32'h0002_2000);
        release_seq(1'b0);
        release_seq(1'b1);
        chk(left, 32'h0000_0002);
        acc(1'b1, 4'h4, 32'h0102_0000);
        pulse(4);
        chk(src, itc_pkg::ITC_ACK_NACK);
        chk(ack_nack, 1'b1);
        pulse(4);
        chk({rwf, hcl, left}, 32'h0000_0300);
        acc(1'b1, 4'h4, 32'h0103_0000);
        chk({rwf, hcl, left}, 32'h0000_0003);
        acc(1'b1, 4'h4, 32'h0000_E000);
        acc(1'b1, 4'h8, 32'h0000_0000);
        rd(4'h4, 32'h0000_0000);
        acc(1'b1, 4'h8, 32'h0000_0001);
        acc(1'b1, 4'h4, 32'h0000_8000);
        chk(ack_nack, 1'b1);
        pulse(3);
        chk(ack_nack, 1'b0);
        @(posedge ref_clk);
        overrun <= 1'b1;
        #1;
        chk(ack_nack, 1'b1);
        end_sim();
    end
endmodule
